// *** hw/iec_counter.sv ***
// Functional notes
// (RL1) Count encoder steps only while the run control is set.
// (RL2) Rising edge of preset load copies the preset value into the count.
// (RL3) Count is always presented on the count output.
// (RL4) Zero flag sets at count zero and holds until a zero acknowledge edge. The design sets it at count zero only while run is set.
// (RL5) Window source select: 0 home switch, 1 program window open request.
// (RL6) Repeat select: 0 reference once after start, 1 every pulse in window.
// (RL7) Reference value loads only with window open and a marker edge together.
// (RL8) Opening the window raises the window active flag.
// (RL9) Reference load clears window active, sets complete until window reopens.
// (RL10) Marker is taken on its rising edge.
// (RL11) Window opener keeps the window shorter than one marker period.
// (RL12) Quadrature decode counts every edge of both tracks. The design counts no step when both tracks change in the same cycle.
// (RL13) Encoder keeps each track below 40 kHz.
// (RL14) The counter itself raises no interrupt; status outputs report conditions. The design also drives IRQ from the masked bus events.
// (RL15) Tracks, marker and home switch pass a two-stage synchroniser.
// (RL16) A leading B increments, B leading A decrements.
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
module iec_counter (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic ENC_A,
  input wire logic ENC_B,
  input wire logic REF_MARKER,
  input wire logic HOME_SWITCH,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic [iec_pkg::CNT_W-1:0] COUNT,
  output logic ZERO,
  output logic REFERENCE_WINDOW_ACTIVE,
  output logic REFERENCE_COMPLETE,
  output logic IRQ
);
  import iec_pkg::*;

  // State read by the bus read mux, declared ahead of its use
  logic [CNT_W-1:0] count_ff;
  logic zero_ff;
  logic active_ff;
  logic done_ff;

  // =========================================================
  // Input synchronisers
  // =========================================================
  iec_pins_t pins_in;
  iec_pins_t sync1_ff;
  iec_pins_t sync2_ff;
  iec_pins_t prev_ff;

  assign pins_in = '{a: ENC_A, b: ENC_B, marker: REF_MARKER, home: HOME_SWITCH};

  // (RL15) two-stage synchroniser
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff <= '0;
    end else begin
      sync1_ff <= pins_in;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // =========================================================
  // Bus registers
  // =========================================================
  iec_ctrl_t ctrl_ff;
  iec_ctrl_t ctrl_prev_ff;
  logic [CNT_W-1:0] preset_ff;
  logic [EV_W-1:0] event_ff;
  logic [EV_W-1:0] mask_ff;
  logic wb_req;
  logic wb_wr;
  logic [31:0] wr_mask;
  logic [31:0] nxt_dat;

  assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wb_wr = wb_req && WB_WE_I;
  assign wr_mask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

  // One wait-free cycle: ack follows the request edge, then drops
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= wb_req;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ctrl_ff <= CTRL_RST;
      preset_ff <= COUNT_RST;
      mask_ff <= MASK_RST;
    end else if (wb_wr) begin
      case (WB_ADR_I)
        ADR_CTRL: begin
          if (WB_SEL_I[0]) begin
            ctrl_ff <= WB_DAT_I[5:0];
          end
        end
        ADR_PRESET: begin
          preset_ff <= (preset_ff & ~wr_mask) | (WB_DAT_I & wr_mask);
        end
        ADR_MASK: begin
          if (WB_SEL_I[0]) begin
            mask_ff <= WB_DAT_I[EV_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ctrl_prev_ff <= CTRL_RST;
    end else begin
      ctrl_prev_ff <= ctrl_ff;
    end
  end

  always_comb begin
    case (WB_ADR_I)
      ADR_CTRL: nxt_dat = {26'h0, ctrl_ff};
      ADR_PRESET: nxt_dat = preset_ff;
      ADR_COUNT: nxt_dat = count_ff;
      ADR_STATUS: nxt_dat = {29'h0, done_ff, active_ff, zero_ff};
      ADR_EVENT: nxt_dat = {30'h0, event_ff};
      ADR_MASK: nxt_dat = {30'h0, mask_ff};
      default: nxt_dat = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      WB_DAT_O <= 32'h00000000;
    end else if (wb_req && !WB_WE_I) begin
      WB_DAT_O <= nxt_dat;
    end
  end

  // =========================================================
  // Quadrature decoder and counter
  // =========================================================
  logic step;
  logic up;
  logic preset_rise;
  logic window_open;
  logic window_prev_ff;
  logic window_rise;
  logic marker_rise;
  logic ref_load;
  logic first_done_ff;

  // (RL12) an edge on one track alone is one step; edges on both tracks in one cycle give none
  assign step = (sync2_ff.a ^ prev_ff.a) ^ (sync2_ff.b ^ prev_ff.b);
  // (RL16) A leading B counts up
  assign up = sync2_ff.a ^ prev_ff.b;

  // (RL2) preset on rising edge
  assign preset_rise = ctrl_ff.preset_load && !ctrl_prev_ff.preset_load;

  // (RL5) window source select
  assign window_open = ctrl_ff.win_src ? ctrl_ff.win_open : sync2_ff.home;
  assign window_rise = window_open && !window_prev_ff;
  // (RL10) marker taken on its rising edge
  assign marker_rise = sync2_ff.marker && !prev_ff.marker;
  // (RL7) (RL6) reference load in open window, once or every time
  assign ref_load = ctrl_ff.run && window_open && marker_rise && (ctrl_ff.repeat_sel || !first_done_ff);

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      window_prev_ff <= 1'b0;
    end else begin
      window_prev_ff <= window_open;
    end
  end

  // Load wins over a simultaneous step so the reference is exact
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      count_ff <= COUNT_RST;
    end else if (preset_rise || ref_load) begin
      count_ff <= preset_ff;
    // (RL1) count only in run state
    end else if (ctrl_ff.run && step) begin
      count_ff <= up ? count_ff + 1'b1 : count_ff - 1'b1;
    end
  end

  // Run low is the halted state; leaving it rearms the once-only mode
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      first_done_ff <= 1'b0;
    end else if (!ctrl_ff.run) begin
      first_done_ff <= 1'b0;
    end else if (ref_load) begin
      first_done_ff <= 1'b1;
    end
  end

  // =========================================================
  // Status flags
  // =========================================================
  logic zero_ack_rise;

  assign zero_ack_rise = ctrl_ff.zero_ack && !ctrl_prev_ff.zero_ack;

  // (RL4) sticky zero, set beats acknowledge
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      zero_ff <= 1'b0;
    end else if (count_ff == COUNT_RST) begin
      zero_ff <= ctrl_ff.run ? 1'b1 : zero_ff & ~zero_ack_rise;
    end else if (zero_ack_rise) begin
      zero_ff <= 1'b0;
    end
  end

  // (RL8) (RL9) active on window open, done on reference load
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      active_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (ref_load) begin
      active_ff <= 1'b0;
      done_ff <= 1'b1;
    end else if (window_rise) begin
      active_ff <= 1'b1;
      done_ff <= 1'b0;
    end
  end

  // =========================================================
  // Bus-side events
  // =========================================================
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;

  // Event marks the cycle the sticky zero flag is about to set
  assign ev_set = {ref_load, ctrl_ff.run && count_ff == COUNT_RST && !zero_ff};
  assign ev_clr = (wb_wr && WB_ADR_I == ADR_EVENT && WB_SEL_I[0]) ? WB_DAT_I[EV_W-1:0] : 2'h0;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      event_ff <= MASK_RST;
    end else begin
      event_ff <= (event_ff & ~ev_clr) | ev_set;
    end
  end

  // =========================================================
  // Outputs
  // =========================================================
  // (RL3) (RL14) count and flags straight from flops
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      COUNT <= COUNT_RST;
      ZERO <= 1'b0;
      REFERENCE_WINDOW_ACTIVE <= 1'b0;
      REFERENCE_COMPLETE <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      COUNT <= count_ff;
      ZERO <= zero_ff;
      REFERENCE_WINDOW_ACTIVE <= active_ff;
      REFERENCE_COMPLETE <= done_ff;
      IRQ <= |(event_ff & mask_ff);
    end
  end

endmodule : iec_counter

// *** hw/iec_pkg.sv ***
package iec_pkg;

  // =========================================================
  // Widths
  // =========================================================
  localparam int CNT_W = 32;

  // =========================================================
  // Register map (byte addresses)
  // =========================================================
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_PRESET = 8'h04;
  localparam logic [7:0] ADR_COUNT = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0C;
  localparam logic [7:0] ADR_EVENT = 8'h10;
  localparam logic [7:0] ADR_MASK = 8'h14;

  // =========================================================
  // Control field positions
  // =========================================================
  localparam int CTRL_RUN = 0;
  localparam int CTRL_PRESET_LOAD = 1;
  localparam int CTRL_ZERO_ACK = 2;
  localparam int CTRL_REPEAT = 3;
  localparam int CTRL_WIN_SRC = 4;
  localparam int CTRL_WIN_OPEN = 5;

  // =========================================================
  // Status / event field positions
  // =========================================================
  localparam int ST_ZERO = 0;
  localparam int ST_REF_ACTIVE = 1;
  localparam int ST_REF_DONE = 2;
  localparam int EV_ZERO = 0;
  localparam int EV_REF_DONE = 1;
  localparam int EV_W = 2;

  // =========================================================
  // Reset values
  // =========================================================
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [EV_W-1:0] MASK_RST = 2'h0;
  localparam logic [CNT_W-1:0] COUNT_RST = 32'h00000000;

  // =========================================================
  // Carriers
  // =========================================================
  typedef struct packed {
    logic a;
    logic b;
    logic marker;
    logic home;
  } iec_pins_t;

  typedef struct packed {
    logic win_open;
    logic win_src;
    logic repeat_sel;
    logic zero_ack;
    logic preset_load;
    logic run;
  } iec_ctrl_t;

endpackage : iec_pkg

// *** testbench/iec_counter_assertions.sv ***
module iec_counter_assertions (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic ENC_A,
  input wire logic ENC_B,
  input wire logic REF_MARKER,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic [iec_pkg::CNT_W-1:0] COUNT,
  input wire logic ZERO,
  input wire logic REFERENCE_WINDOW_ACTIVE,
  input wire logic REFERENCE_COMPLETE
);
  // ==========
  // Checks
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("no ack");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("long ack");
  ack_cause_a: assert property ($rose(WB_ACK_O) |-> $past(WB_STB_I)) else $error("stray ack");
  unmapped_a: assert property (WB_ACK_O && !$past(WB_WE_I) && $past(WB_ADR_I) > 8'h14 |-> WB_DAT_O == 32'h0)
    else $error("unmapped data");
  // Quiet pins and bus must leave the count alone
  count_hold_a: assert property ((!WB_STB_I && !REF_MARKER && $stable(ENC_A) && $stable(ENC_B))[*6]
    |=> $stable(COUNT)) else $error("count moved");
  zero_hold_a: assert property ((ZERO && !WB_STB_I)[*6] |=> ZERO) else $error("zero lost");
  zero_cause_a: assert property ($rose(ZERO) |-> ##[0:2] COUNT == 32'h0) else $error("zero early");
  done_clear_a: assert property ($rose(REFERENCE_COMPLETE) |-> ##[0:1] !REFERENCE_WINDOW_ACTIVE)
    else $error("active kept");
  reopen_a: assert property ($rose(REFERENCE_WINDOW_ACTIVE) |-> ##[0:1] !REFERENCE_COMPLETE)
    else $error("done kept");
endmodule : iec_counter_assertions

bind iec_counter iec_counter_assertions chk_u (.CLK(CLK), .RESETN(RESETN), .ENC_A(ENC_A), .ENC_B(ENC_B),
  .REF_MARKER(REF_MARKER), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .COUNT(COUNT), .ZERO(ZERO),
  .REFERENCE_WINDOW_ACTIVE(REFERENCE_WINDOW_ACTIVE), .REFERENCE_COMPLETE(REFERENCE_COMPLETE));

// *** testbench/iec_encoder_model.sv ***
module iec_encoder_model (
  input wire logic clk,
  output logic a,
  output logic b,
  output logic marker,
  output logic home
);
  timeunit 1ns;
  timeprecision 1ns;
  int ph = 0;
  initial begin
    a = 1'b0;
    b = 1'b0;
    marker = 1'b0;
    home = 1'b0;
  end
  // ==========
  // Tracks
  // quadrature, A leads B upward
  // 64 cycles per edge keeps a track under the limit
  task automatic move(input int n);
    repeat (n < 0 ? -n : n) begin
      @(posedge clk);
      ph = (ph + (n < 0 ? 3 : 1)) % 4;
      a <= ph == 1 || ph == 2;
      b <= ph >= 2;
      repeat (63) @(posedge clk);
    end
  endtask : move
  task automatic pulse;
    @(posedge clk);
    marker <= 1'b1;
    repeat (8) @(posedge clk);
    marker <= 1'b0;
  endtask : pulse
  task automatic set_home(input logic v);
    @(posedge clk);
    home <= v;
  endtask : set_home
endmodule : iec_encoder_model

// *** testbench/iec_counter_bench.sv ***
module iec_counter_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import iec_pkg::*;
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wd = 32'h0, rd, c = 32'h0, lf = 32'h866E, r, dat;
  logic ack, zero, act, done, irq, ea, eb, mk, hm;
  logic [CNT_W-1:0] cnt;
  int bad_count = 0, tests_run = 0, ex = 0;
  iec_counter dut_u (.CLK(clk), .RESETN(rst_n), .ENC_A(ea), .ENC_B(eb), .REF_MARKER(mk), .HOME_SWITCH(hm),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd),
    .WB_DAT_O(dat), .WB_ACK_O(ack), .COUNT(cnt), .ZERO(zero), .REFERENCE_WINDOW_ACTIVE(act),
    .REFERENCE_COMPLETE(done), .IRQ(irq));
  iec_encoder_model enc_u (.clk(clk), .a(ea), .b(eb), .marker(mk), .home(hm));
  initial forever #50 clk = ~clk;
  // ==========
  // Helpers
  task automatic ck(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : ck
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 20);
    if (t >= 20) begin
      bad_count++;
      tally_and_finish;
    end
    rd = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic ctl(input logic [31:0] m);
    c = m;
    bus(1'b1, ADR_CTRL, c);
  endtask : ctl
  task automatic pre(input logic [31:0] p);
    bus(1'b1, ADR_PRESET, p);
    ctl(c | 32'h2);
    ctl(c & ~32'h2);
    ex = p;
    repeat (4) @(posedge clk);
  endtask : pre
  task automatic mv(input int n);
    enc_u.move(n);
    ex += n;
    repeat (6) @(posedge clk);
  endtask : mv
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    tally_and_finish;
  end
  // ==========
  // Sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, ADR_MASK, 32'h0);
    ck("mask", rd, 32'(MASK_RST));
    bus(1'b0, 8'h20, 32'h0);
    ck("unmapped", rd, 32'h0);
    enc_u.move(2);
    ck("halted", cnt, COUNT_RST);
    $display("reset test done");
    ctl(32'h1);
    lf = nx(lf);
    pre(lf | 32'h100);
    ck("preset", cnt, 32'(ex));
    bus(1'b0, ADR_COUNT, 32'h0);
    ck("read count", rd, 32'(ex));
    ctl(c | 32'h4);
    ctl(c & ~32'h4);
    for (int i = 0; i < 3; i++) begin
      lf = nx(lf);
      mv(int'(lf[2:0]) - 3);
    end
    ck("steps", cnt, 32'(ex));
    $display("count test done");
    pre(32'h2);
    bus(1'b1, ADR_MASK, 32'h1);
    mv(-2);
    ck("zero", zero, 32'h1);
    ck("irq", irq, 32'h1);
    mv(1);
    ck("zero held", zero, 32'h1);
    ctl(c | 32'h4);
    ctl(c & ~32'h4);
    bus(1'b1, ADR_EVENT, 32'h1);
    repeat (3) @(posedge clk);
    ck("zero ack", zero, 32'h0);
    ck("irq clear", irq, 32'h0);
    $display("zero test done");
    // windows stay short, one marker each
    r = nx(lf);
    bus(1'b1, ADR_PRESET, r);
    enc_u.set_home(1'b1);
    repeat (8) @(posedge clk);
    ck("active", act, 32'h1);
    enc_u.pulse;
    repeat (6) @(posedge clk);
    ck("ref load", cnt, r);
    ck("done", {act, done}, 32'h1);
    enc_u.set_home(1'b0);
    bus(1'b1, ADR_PRESET, r ^ 32'hFF);
    enc_u.set_home(1'b1);
    repeat (8) @(posedge clk);
    ck("reopen", done, 32'h0);
    enc_u.pulse;
    repeat (6) @(posedge clk);
    ck("once", cnt, r);
    enc_u.set_home(1'b0);
    ctl(c | 32'h18);
    enc_u.set_home(1'b1);
    repeat (8) @(posedge clk);
    enc_u.pulse;
    repeat (6) @(posedge clk);
    ck("switch ignored", cnt, r);
    enc_u.set_home(1'b0);
    ctl(c | 32'h20);
    repeat (8) @(posedge clk);
    ck("soft active", act, 32'h1);
    enc_u.pulse;
    repeat (6) @(posedge clk);
    ck("repeat", cnt, r ^ 32'hFF);
    $display("reference test done");
    tally_and_finish;
  end
endmodule : iec_counter_bench
